// [design/uart_pins_pkg.sv]
// package: constants and carrier types for the uart host bus and serial pin block
package uart_pins_pkg;
  localparam int unsigned clk_freq_mhz = 50;
  localparam int unsigned reset_min_ns = 40;
  localparam int unsigned reset_min_cycles = (reset_min_ns * clk_freq_mhz + 999) / 1000;
  localparam int unsigned sync_stages = 2;
  localparam int unsigned addr_width = 3;
  localparam int unsigned data_width = 8;
  localparam int unsigned reg_count = 8;

  // register indices chosen by the three select lines
  localparam logic [2:0] idx_data = 3'h0;
  localparam logic [2:0] idx_irq_enable = 3'h1;
  localparam logic [2:0] idx_irq_ident = 3'h2;
  localparam logic [2:0] idx_line_control = 3'h3;
  localparam logic [2:0] idx_modem_control = 3'h4;
  localparam logic [2:0] idx_line_status = 3'h5;
  localparam logic [2:0] idx_modem_status = 3'h6;
  localparam logic [2:0] idx_scratch = 3'h7;

  // field positions
  localparam int unsigned mcr_rts_bit = 1;
  localparam int unsigned mcr_dtr_bit = 0;
  localparam int unsigned mcr_irq_drive_bit = 3;
  localparam int unsigned mcr_infrared_bit = 6;
  localparam int unsigned msr_cts_bit = 4;
  localparam int unsigned efr_auto_rts_bit = 6;
  localparam int unsigned efr_auto_cts_bit = 7;
  localparam int unsigned ier_rts_bit = 6;
  localparam int unsigned ier_cts_bit = 7;

  // reset values
  localparam logic [7:0] reg_reset_value = 8'h00;
  localparam logic [7:0] ident_reset_value = 8'h01;

  typedef enum logic [1:0]
  {
    acc_idle = 2'b00,
    acc_read = 2'b01,
    acc_write = 2'b10
  } access_state_type;

  // synchronised host bus view
  typedef struct packed
  {
    logic chip_sel_n;
    logic read_strobe_n;
    logic write_strobe_n;
  } bus_ctrl_type;

  typedef struct packed
  {
    logic [2:0] sel;
    logic [7:0] data;
  } bus_word_type;
endpackage

// [design/pin_sync.sv]
// two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module pin_sync
  import uart_pins_pkg::*;
#(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] stable_d;

  always_comb
  begin
    meta_d = async_in;
    stable_d = meta_q;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_q <= INIT;
      stable_q <= INIT;
    end
    else
    begin
      meta_q <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign sync_out = stable_q;
endmodule

// [design/uart_host_pins.sv]
// host bus decode, register file and serial/modem pin control of the uart
`timescale 1ns/1ps
module uart_host_pins
  import uart_pins_pkg::*;
(
  // clock and reset (polarity already resolved from the bus style)
  input wire logic clk_in,
  input wire logic rst_in,
  // bus style strap: 1 strobe pair, 0 direction line
  input wire logic bus_style_in,
  // host bus
  input wire logic chip_sel_n_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic reg_sel_2_in,
  input wire logic reg_sel_1_in,
  input wire logic reg_sel_0_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n_out,
  // interrupt pin
  input wire logic irq_request_in,
  output logic irq_out,
  output logic irq_oe_n_out,
  // serial pins and core serial path
  input wire logic tx_serial_in,
  input wire logic tx_infrared_in,
  input wire logic tx_busy_in,
  output logic tx_out,
  input wire logic rx_in,
  output logic rx_serial_out,
  output logic rx_infrared_out,
  output logic infrared_mode_out,
  // modem pins
  output logic rts_n_out,
  output logic dtr_n_out,
  input wire logic cts_n_in,
  input wire logic rts_auto_deassert_in,
  output logic tx_allowed_out,
  // core register side
  input wire logic [7:0] line_status_in,
  input wire logic [7:0] irq_ident_in,
  input wire logic [7:0] rx_data_in,
  output logic [7:0] tx_data_out,
  output logic tx_data_strobe_out,
  output logic rx_data_read_out,
  output logic [7:0] line_control_out,
  input wire logic [7:0] enhanced_feature_reg_in
);
  logic [2:0] ctrl_sync;
  logic [10:0] word_sync;
  logic rx_sync;
  logic cts_sync;
  bus_ctrl_type ctrl;
  bus_word_type word;

  // strobes, select lines and data all come from the host's timing domain
  pin_sync #(.WIDTH(3), .INIT(3'h7)) u_ctrl_sync
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({chip_sel_n_in, read_strobe_n_in, write_strobe_n_in}),
    .sync_out(ctrl_sync)
  );
  pin_sync #(.WIDTH(11), .INIT(11'h000)) u_word_sync
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({reg_sel_2_in, reg_sel_1_in, reg_sel_0_in, data_in}),
    .sync_out(word_sync)
  );
  pin_sync #(.WIDTH(2), .INIT(2'h3)) u_line_sync
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({rx_in, cts_n_in}),
    .sync_out({rx_sync, cts_sync})
  );

  assign ctrl = bus_ctrl_type'(ctrl_sync);
  assign word = bus_word_type'(word_sync);

  // registers owned by this block
  logic [7:0] modem_control_reg_q, modem_control_reg_d;
  logic [7:0] irq_enable_reg_q, irq_enable_reg_d;
  logic [7:0] line_control_q, line_control_d;
  logic [7:0] scratch_q, scratch_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic tx_strobe_q, tx_strobe_d;
  logic rx_read_q, rx_read_d;
  logic [7:0] read_data_q, read_data_d;
  logic drive_q, drive_d;
  access_state_type state_q, state_d;
  logic [2:0] sel_q, sel_d;
  logic [7:0] modem_status_reg;

  // strobe-pair style uses two strobes; direction style uses chip select with the write strobe pin as direction, high for read
  logic rd_active, wr_active;
  always_comb
  begin
    rd_active = 1'b0;
    wr_active = 1'b0;
    if (!ctrl.chip_sel_n)
    begin
      if (bus_style_in)
      begin
        rd_active = !ctrl.read_strobe_n;
        wr_active = !ctrl.write_strobe_n;
      end
      else
      begin
        // read strobe pin not looked at here
        rd_active = ctrl.write_strobe_n;
        wr_active = !ctrl.write_strobe_n;
      end
    end
  end

  function automatic logic [7:0] read_mux(input logic [2:0] sel);
    logic [7:0] v;
    v = 8'h00;
    unique case (sel)
      idx_data: v = rx_data_in;
      idx_irq_enable: v = irq_enable_reg_q;
      idx_irq_ident: v = irq_ident_in;
      idx_line_control: v = line_control_q;
      idx_modem_control: v = modem_control_reg_q;
      idx_line_status: v = line_status_in;
      idx_modem_status: v = modem_status_reg;
      idx_scratch: v = scratch_q;
    endcase
    return v;
  endfunction

  always_comb
  begin
    modem_status_reg = 8'h00;
    modem_status_reg[msr_cts_bit] = !cts_sync;
  end

  always_comb
  begin
    state_d = state_q;
    sel_d = sel_q;
    modem_control_reg_d = modem_control_reg_q;
    irq_enable_reg_d = irq_enable_reg_q;
    line_control_d = line_control_q;
    scratch_d = scratch_q;
    tx_data_d = tx_data_q;
    tx_strobe_d = 1'b0;
    rx_read_d = 1'b0;
    read_data_d = read_data_q;
    drive_d = 1'b0;
    unique case (state_q)
      acc_idle:
      begin
        if (rd_active)
        begin
          // falling edge: capture the address and fetch the byte
          state_d = acc_read;
          sel_d = word.sel;
          read_data_d = read_mux(word.sel);
          drive_d = 1'b1;
          rx_read_d = (word.sel == idx_data);
        end
        else if (wr_active)
        begin
          state_d = acc_write;
          sel_d = word.sel;
        end
      end
      acc_read:
      begin
        drive_d = rd_active;
        if (rd_active)
        begin
          read_data_d = read_mux(sel_q);
        end
        else
        begin
          state_d = acc_idle;
        end
      end
      acc_write:
      begin
        // latching on release means one write per strobe, whatever its length
        if (!wr_active)
        begin
          state_d = acc_idle;
          unique case (sel_q)
            idx_data:
            begin
              tx_data_d = word.data;
              tx_strobe_d = 1'b1;
            end
            idx_irq_enable: irq_enable_reg_d = word.data;
            idx_line_control: line_control_d = word.data;
            idx_modem_control: modem_control_reg_d = word.data;
            idx_scratch: scratch_d = word.data;
            default:
            begin
            end
          endcase
        end
      end
      default: state_d = acc_idle;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= acc_idle;
      sel_q <= 3'h0;
      modem_control_reg_q <= reg_reset_value;
      irq_enable_reg_q <= reg_reset_value;
      line_control_q <= reg_reset_value;
      scratch_q <= reg_reset_value;
      tx_data_q <= reg_reset_value;
      tx_strobe_q <= 1'b0;
      rx_read_q <= 1'b0;
      read_data_q <= reg_reset_value;
      drive_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      sel_q <= sel_d;
      modem_control_reg_q <= modem_control_reg_d;
      irq_enable_reg_q <= irq_enable_reg_d;
      line_control_q <= line_control_d;
      scratch_q <= scratch_d;
      tx_data_q <= tx_data_d;
      tx_strobe_q <= tx_strobe_d;
      rx_read_q <= rx_read_d;
      read_data_q <= read_data_d;
      drive_q <= drive_d;
    end
  end

  // pin output stage, registered so pins never glitch
  logic infrared_q, infrared_d;
  logic tx_q, tx_d;
  logic irq_q, irq_d;
  logic irq_oe_n_q, irq_oe_n_d;
  logic rts_n_q, rts_n_d;
  logic dtr_n_q, dtr_n_d;
  logic tx_allowed_q, tx_allowed_d;

  always_comb
  begin
    infrared_d = modem_control_reg_q[mcr_infrared_bit];
    if (infrared_d)
    begin
      tx_d = tx_busy_in ? tx_infrared_in : 1'b0;
    end
    else
    begin
      tx_d = tx_busy_in ? tx_serial_in : 1'b1;
    end
    if (bus_style_in)
    begin
      irq_d = irq_request_in;
      irq_oe_n_d = !modem_control_reg_q[mcr_irq_drive_bit];
    end
    else
    begin
      // open drain: drive only the low level, pull-up makes the high
      irq_d = 1'b0;
      irq_oe_n_d = !irq_request_in;
    end
    // auto deassert only acts once software has asserted the line
    rts_n_d = !(modem_control_reg_q[mcr_rts_bit]
      && !(enhanced_feature_reg_in[efr_auto_rts_bit] && rts_auto_deassert_in));
    dtr_n_d = !modem_control_reg_q[mcr_dtr_bit];
    tx_allowed_d = !enhanced_feature_reg_in[efr_auto_cts_bit] || !cts_sync;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      infrared_q <= 1'b0;
      tx_q <= 1'b1;
      irq_q <= 1'b0;
      irq_oe_n_q <= 1'b1;
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
      tx_allowed_q <= 1'b0;
    end
    else
    begin
      infrared_q <= infrared_d;
      tx_q <= tx_d;
      irq_q <= irq_d;
      irq_oe_n_q <= irq_oe_n_d;
      rts_n_q <= rts_n_d;
      dtr_n_q <= dtr_n_d;
      tx_allowed_q <= tx_allowed_d;
    end
  end

  assign data_out = read_data_q;
  assign data_oe_n_out = !drive_q;
  assign irq_out = irq_q;
  assign irq_oe_n_out = irq_oe_n_q;
  assign tx_out = tx_q;
  // receive ignored while in reset: synchroniser resets to idle
  assign rx_serial_out = infrared_q ? 1'b1 : rx_sync;
  assign rx_infrared_out = infrared_q ? rx_sync : 1'b0;
  assign infrared_mode_out = infrared_q;
  assign rts_n_out = rts_n_q;
  assign dtr_n_out = dtr_n_q;
  assign tx_allowed_out = tx_allowed_q;
  assign tx_data_out = tx_data_q;
  assign tx_data_strobe_out = tx_strobe_q;
  assign rx_data_read_out = rx_read_q;
  assign line_control_out = line_control_q;
endmodule

// [tb/uart_host_pins_chk.sv]
// concurrent checks on the uart pin block ports
`timescale 1ns/1ps
module uart_host_pins_chk
(
  // watched ports
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic bus_style_in,
  input wire logic chip_sel_n_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic irq_request_in,
  input wire logic tx_busy_in,
  input wire logic data_oe_n_out,
  input wire logic irq_out,
  input wire logic irq_oe_n_out,
  input wire logic tx_out,
  input wire logic infrared_mode_out,
  input wire logic tx_data_strobe_out,
  input wire logic rx_data_read_out
);
  logic [3:0] cs_hi_q;
  logic [3:0] cs_hi_d;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // saturating count of cycles with chip select high
  always_comb cs_hi_d = chip_sel_n_in ? (cs_hi_q == 4'hf ? cs_hi_q : cs_hi_q + 4'h1) : 4'h0;
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      cs_hi_q <= 4'h0;
    else
      cs_hi_q <= cs_hi_d;
  AST_DATA_RELEASE: assert property (cs_hi_q >= 4'h6 |-> data_oe_n_out)
    else $error("data bus driven while deselected");
  AST_READ_STROBE: assert property ($fell(data_oe_n_out) && bus_style_in
    |-> !$past(read_strobe_n_in, 2) && !$past(chip_sel_n_in, 2))
    else $error("read without read strobe");
  AST_DIR_READ: assert property ($fell(data_oe_n_out) && !bus_style_in
    |-> $past(write_strobe_n_in, 2) && !$past(chip_sel_n_in, 2))
    else $error("read without direction high");
  AST_WRITE_PULSE: assert property (tx_data_strobe_out |=> !tx_data_strobe_out)
    else $error("write pulse longer than one cycle");
  AST_WRITE_SELECT: assert property (tx_data_strobe_out |-> !$past(chip_sel_n_in, 5))
    else $error("write without chip select");
  AST_IRQ_HIGH: assert property (bus_style_in && !irq_oe_n_out && $past(!irq_oe_n_out)
    |-> irq_out == $past(irq_request_in))
    else $error("interrupt level wrong");
  AST_IRQ_OPEN_DRAIN: assert property (!bus_style_in && !irq_oe_n_out |-> !irq_out)
    else $error("open drain interrupt drives high");
  AST_TX_IDLE: assert property (!infrared_mode_out && $past(!infrared_mode_out)
    && $past(!tx_busy_in) |-> tx_out)
    else $error("transmit not idle high");
  // first edge of the run may precede the reset taking hold
  AST_TX_RESET: assert property (disable iff (1'b0) rst_in && $past(rst_in) |-> tx_out)
    else $error("transmit low in reset");
  AST_RX_READ_PULSE: assert property (rx_data_read_out
    |-> $fell(data_oe_n_out) ##1 !rx_data_read_out)
    else $error("receive read pulse not single or not with a read");
  cover property ($fell(data_oe_n_out) && bus_style_in);
  cover property ($fell(data_oe_n_out) && !bus_style_in);
  cover property (tx_data_strobe_out);
  cover property (infrared_mode_out);
endmodule
bind uart_host_pins uart_host_pins_chk chk
(
  .clk_in(clk_in), .rst_in(rst_in), .bus_style_in(bus_style_in), .chip_sel_n_in(chip_sel_n_in),
  .read_strobe_n_in(read_strobe_n_in), .write_strobe_n_in(write_strobe_n_in),
  .irq_request_in(irq_request_in), .tx_busy_in(tx_busy_in), .data_oe_n_out(data_oe_n_out),
  .irq_out(irq_out), .irq_oe_n_out(irq_oe_n_out), .tx_out(tx_out),
  .infrared_mode_out(infrared_mode_out), .tx_data_strobe_out(tx_data_strobe_out),
  .rx_data_read_out(rx_data_read_out)
);

// [tb/host_model.sv]
// host bus and receive line model facing the uart pin block
`timescale 1ns/1ps
module host_model
(
  // clock and modes
  input wire logic clk_in,
  input wire logic bus_style_in,
  input wire logic infrared_mode_in,
  // device side
  input wire logic [7:0] dev_data_in,
  input wire logic dev_oe_n_in,
  // host pins
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [2:0] sel_out,
  output logic [7:0] data_out,
  output logic rx_out
);
  logic drive_q = 1'b0;
  logic [7:0] wdata_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  initial
  begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    sel_out = 3'h0;
  end
  // a floating bus flips every cycle so no stale byte can match
  assign data_out = drive_q ? wdata_q : (!dev_oe_n_in ? dev_data_in : ~last_q);
  always @(posedge clk_in) last_q <= data_out;
  assign rx_out = !infrared_mode_in;
  // select, data and direction held well past the release
  task automatic access(input logic en, input logic wr, input logic [2:0] sel,
    input logic [7:0] wd, output logic [7:0] rd, output logic seen);
    @(posedge clk_in);
    sel_out <= sel;
    wdata_q <= wd;
    drive_q <= wr;
    cs_n_out <= !en;
    wr_n_out <= !wr;
    rd_n_out <= (bus_style_in == wr);
    repeat (6) @(posedge clk_in);
    rd = dev_data_in;
    seen = !dev_oe_n_in;
    cs_n_out <= 1'b1;
    rd_n_out <= 1'b1;
    if (bus_style_in)
      wr_n_out <= 1'b1;
    repeat (5) @(posedge clk_in);
    wr_n_out <= 1'b1;
    drive_q <= 1'b0;
  endtask
endmodule

// [tb/testbench.sv]
// self-checking bench for the uart host pin block
`timescale 1ns/1ps
module testbench
  import uart_pins_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic style = 1'b1;
  logic irq_req = 1'b0;
  logic tx_ser = 1'b1;
  logic tx_ir = 1'b0;
  logic tx_busy = 1'b0;
  logic cts_n = 1'b1;
  logic rts_auto = 1'b0;
  logic [7:0] enhanced_feature_reg = 8'h00;
  logic [7:0] lsr = 8'h60;
  logic [7:0] iir = 8'hc1;
  logic [7:0] rxd = 8'h3e;
  logic cs_n, rd_n, wr_n, ir_mode, oe_n, irq, irq_oe_n, tx, rts_n, dtr_n, tx_ok, rx, rx_std, rx_ir;
  logic [2:0] sel;
  logic [7:0] bus, dout, txd, lcr;
  int mismatches = 0;
  int compares = 0;
  always #10 clk_in = ~clk_in;
  uart_host_pins dut
  (
    .clk_in(clk_in), .rst_in(rst_in), .bus_style_in(style), .chip_sel_n_in(cs_n),
    .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .reg_sel_2_in(sel[2]),
    .reg_sel_1_in(sel[1]), .reg_sel_0_in(sel[0]), .data_in(bus), .data_out(dout),
    .data_oe_n_out(oe_n), .irq_request_in(irq_req), .irq_out(irq), .irq_oe_n_out(irq_oe_n),
    .tx_serial_in(tx_ser), .tx_infrared_in(tx_ir), .tx_busy_in(tx_busy), .tx_out(tx),
    .rx_in(rx), .rx_serial_out(rx_std), .rx_infrared_out(rx_ir), .infrared_mode_out(ir_mode),
    .rts_n_out(rts_n), .dtr_n_out(dtr_n), .cts_n_in(cts_n), .rts_auto_deassert_in(rts_auto),
    .tx_allowed_out(tx_ok), .line_status_in(lsr), .irq_ident_in(iir), .rx_data_in(rxd),
    .tx_data_out(txd), .tx_data_strobe_out(), .rx_data_read_out(), .line_control_out(lcr),
    .enhanced_feature_reg_in(enhanced_feature_reg)
  );
  host_model host
  (
    .clk_in(clk_in), .bus_style_in(style), .infrared_mode_in(ir_mode), .dev_data_in(dout),
    .dev_oe_n_in(oe_n), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .sel_out(sel),
    .data_out(bus), .rx_out(rx)
  );
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] v);
    logic [7:0] d;
    logic f;
    host.access(1'b1, 1'b1, s, v, d, f);
  endtask
  task automatic rdc(input logic [2:0] s, input logic [7:0] e);
    logic [7:0] d;
    logic f;
    host.access(1'b1, 1'b0, s, 8'h00, d, f);
    chk1(f, 1'b1);
    chk8(d, e);
  endtask
  // lands on a falling edge so registered outputs have settled
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #1500000;
    mismatches++;
    results;
  end
  initial
  begin
    logic [7:0] v;
    logic [7:0] d;
    logic f;
    ticks(19);
    chk8({4'h0, tx, oe_n, rts_n, dtr_n}, 8'h0f);
    chk1(irq_oe_n, 1'b1);
    @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      v = 8'ha0 | 8'(i);
      wr(3'(i), v);
      if (i != 6)
        rdc(3'(i), i == 0 ? rxd : i == 2 ? iir : i == 5 ? lsr : v);
    end
    chk8(txd, 8'ha0);
    chk8(lcr, 8'ha3);
    host.access(1'b0, 1'b1, idx_scratch, 8'h3c, d, f);
    host.access(1'b0, 1'b0, idx_scratch, 8'h00, d, f);
    chk1(f, 1'b0);
    rdc(idx_scratch, 8'ha7);
    $display("test bus done");
    wr(idx_modem_control, 8'h0b);
    chk8({5'h00, rts_n, dtr_n, irq_oe_n}, 8'h00);
    irq_req <= 1'b1;
    ticks(3);
    chk1(irq, 1'b1);
    @(posedge clk_in);
    irq_req <= 1'b0;
    enhanced_feature_reg <= 8'h40;
    rts_auto <= 1'b1;
    ticks(4);
    chk1(rts_n, 1'b1);
    @(posedge clk_in);
    rts_auto <= 1'b0;
    enhanced_feature_reg <= 8'h80;
    wr(idx_modem_control, 8'h40);
    // receive line needs two more edges through its synchroniser
    ticks(2);
    chk8({5'h00, ir_mode, tx, rx_ir}, 8'h04);
    wr(idx_modem_control, 8'h00);
    ticks(2);
    chk8({4'h0, tx, rx_std, irq_oe_n, tx_ok}, 8'h0e);
    @(posedge clk_in);
    tx_busy <= 1'b1;
    tx_ser <= 1'b0;
    cts_n <= 1'b0;
    ticks(4);
    chk8({6'h00, tx, tx_ok}, 8'h01);
    @(posedge clk_in);
    tx_busy <= 1'b0;
    tx_ser <= 1'b1;
    host.access(1'b1, 1'b0, idx_modem_status, 8'h00, d, f);
    chk1(d[msr_cts_bit], 1'b1);
    $display("test modem done");
    @(posedge clk_in);
    rst_in <= 1'b1;
    style <= 1'b0;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rdc(idx_scratch, 8'h00);
    wr(idx_scratch, 8'h5a);
    rdc(idx_scratch, 8'h5a);
    irq_req <= 1'b1;
    ticks(3);
    chk8({6'h00, irq_oe_n, irq}, 8'h00);
    @(posedge clk_in);
    irq_req <= 1'b0;
    ticks(3);
    chk1(irq_oe_n, 1'b1);
    $display("test direction done");
    results;
  end
endmodule
